// *** rtl/pcrb_bank.sv ***
/*
 * pll configuration register bank: config and output gate words for the
 * memory, network, alternate core and peripheral plls, plus the peripheral
 * clock divider value.
 * assumes the clock/reset unit supplies a synchronous reset and that the plls
 * report lock as a level already synchronous to clk_in.
 */
// Our own choice: the address-and-strobe port.
// Operation
// - config word holds ref [5:0]=1, feedback [14:6]=0x1F, output [17:15]=3
// - range [20:18] resets zero; bits [23:21] and [30:26] reserved
// - bypass bit 24 and sense bypass bit 25, both reset to one
// - bit 31 shows live lock while bypass bit 24 is clear, zero in bypass, read only, writes ignored
// - output gate word: enable bit 31 resets zero, rest reserved
// - peripheral divider value: full 32-bit read-write, resets zero
// - separate config words at 0xC, 0x1C, 0x38 and 0x50, same layout
// - gate words at 0x10, 0x20, 0x3C, 0x54 each gate own pll
// - reference divide equals field plus one
// - feedback divide equals two times the sum of field and one
// - output divide is two to the field; above six is unsupported
`timescale 1ns/10ps
module pcrb_bank
    import pcrb_pkg::*;
#(
    parameter int NUM_PLL = PCRB_NUM_CFG
) (
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    input  wire logic [7:0]         addr_in,
    input  wire logic [31:0]        wdata_in,
    input  wire logic               wr_in,
    input  wire logic               rd_in,
    output logic      [31:0]        rdata_out,
    input  wire logic [NUM_PLL-1:0] lock_in,
    output pcrb_ctl_t               ctl_out   [NUM_PLL],
    output logic      [NUM_PLL-1:0] cke_out,
    output logic      [NUM_PLL-1:0] unsupported_out,
    output logic      [31:0]        periph_div_out
);

    pcrb_req_t   req;
    logic [31:0] cfg_rd   [NUM_PLL];
    logic [31:0] gate_rd  [NUM_PLL];
    logic [NUM_PLL-1:0] cfg_wr;
    logic [NUM_PLL-1:0] gate_wr;
    logic        div_wr;
    logic [31:0] div_r;
    logic [31:0] div_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    assign req.addr  = addr_in;
    assign req.wdata = wdata_in;
    assign req.wr    = wr_in;
    assign req.rd    = rd_in;

    // map a pll index to its config word offset
    function automatic logic [7:0] cfg_off(input int idx);
        case (idx)
            PCRB_IDX_MEM: cfg_off = PCRB_OFF_MEM_CFG;
            PCRB_IDX_NET: cfg_off = PCRB_OFF_NET_CFG;
            PCRB_IDX_ALT: cfg_off = PCRB_OFF_ALT_CFG;
            default:      cfg_off = PCRB_OFF_PER_CFG;
        endcase
    endfunction

    // map a pll index to its output gate offset
    function automatic logic [7:0] gate_off(input int idx);
        case (idx)
            PCRB_IDX_MEM: gate_off = PCRB_OFF_MEM_GATE;
            PCRB_IDX_NET: gate_off = PCRB_OFF_NET_GATE;
            PCRB_IDX_ALT: gate_off = PCRB_OFF_ALT_GATE;
            default:      gate_off = PCRB_OFF_PER_GATE;
        endcase
    endfunction

    // one independent config word and gate per pll
    for (genvar i = 0; i < NUM_PLL; i++) begin : g_pll
        assign cfg_wr[i]  = req.wr && (req.addr == cfg_off(i));
        assign gate_wr[i] = req.wr && (req.addr == gate_off(i));

        pcrb_cfg_word u_cfg (
            .clk_in    (clk_in),
            .rst_n_in  (rst_n_in),
            .wr_in     (cfg_wr[i]),
            .wdata_in  (req.wdata),
            .lock_in   (lock_in[i] && !ctl_out[i].bypass),
            .rdata_out (cfg_rd[i]),
            .ctl_out   (ctl_out[i])
        );

        pcrb_out_gate u_gate (
            .clk_in    (clk_in),
            .rst_n_in  (rst_n_in),
            .wr_in     (gate_wr[i]),
            .wdata_in  (req.wdata),
            .rdata_out (gate_rd[i]),
            .cke_out   (cke_out[i])
        );

        assign unsupported_out[i] = ctl_out[i].out_bad;
    end

    // peripheral clock divider value, all 32 bits writable
    assign div_wr = req.wr && (req.addr == PCRB_OFF_PER_DIV);

    always_comb begin
        div_nxt = div_wr ? req.wdata : div_r;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            div_r <= PCRB_DIV_RST;
        end else begin
            div_r <= div_nxt;
        end
    end

    assign periph_div_out = div_r;

    // read mux; unmapped addresses and idle cycles return zero, so the
    // data bus never carries stale values between reads
    always_comb begin
        rdata_nxt = PCRB_ZERO;
        if (req.rd) begin
            for (int i = 0; i < NUM_PLL; i++) begin
                if (req.addr == cfg_off(i)) begin
                    rdata_nxt = cfg_rd[i];
                end
                if (req.addr == gate_off(i)) begin
                    rdata_nxt = gate_rd[i];
                end
            end
            if (req.addr == PCRB_OFF_PER_DIV) begin
                rdata_nxt = div_r;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdata_r <= PCRB_ZERO;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_out = rdata_r;

endmodule

// *** rtl/pcrb_cfg_word.sv ***
/*
 * one pll configuration word: holds the writable fields and turns them into
 * the ratios the analog pll wants.
 * assumes the bank decodes the address and hands in a one-cycle write pulse.
 */
`timescale 1ns/10ps
module pcrb_cfg_word
    import pcrb_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        wr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        lock_in,
    output logic      [31:0] rdata_out,
    output pcrb_ctl_t        ctl_out
);

    pcrb_cfg_t cfg_r;
    pcrb_cfg_t cfg_nxt;

    // capture only the writable fields; reserved and lock bits are dropped
    always_comb begin
        cfg_nxt = cfg_r;
        if (wr_in) begin
            cfg_nxt.ref_div = wdata_in[PCRB_REF_MSB:PCRB_REF_LSB];
            cfg_nxt.fb_div  = wdata_in[PCRB_FB_MSB:PCRB_FB_LSB];
            cfg_nxt.out_div = wdata_in[PCRB_OUT_MSB:PCRB_OUT_LSB];
            cfg_nxt.range   = wdata_in[PCRB_RANGE_MSB:PCRB_RANGE_LSB];
            cfg_nxt.byp     = wdata_in[PCRB_BYP_BIT];
            cfg_nxt.fsebyp  = wdata_in[PCRB_FSEBYP_BIT];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cfg_r.ref_div <= PCRB_REF_RST;
            cfg_r.fb_div  <= PCRB_FB_RST;
            cfg_r.out_div <= PCRB_OUT_RST;
            cfg_r.range   <= PCRB_RANGE_RST;
            cfg_r.byp     <= PCRB_BYP_RST;
            cfg_r.fsebyp  <= PCRB_FSEBYP_RST;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // read view; lock is live, reserved bits stay zero
    always_comb begin
        rdata_out = PCRB_ZERO;
        rdata_out[PCRB_REF_MSB:PCRB_REF_LSB]     = cfg_r.ref_div;
        rdata_out[PCRB_FB_MSB:PCRB_FB_LSB]       = cfg_r.fb_div;
        rdata_out[PCRB_OUT_MSB:PCRB_OUT_LSB]     = cfg_r.out_div;
        rdata_out[PCRB_RANGE_MSB:PCRB_RANGE_LSB] = cfg_r.range;
        rdata_out[PCRB_BYP_BIT]                  = cfg_r.byp;
        rdata_out[PCRB_FSEBYP_BIT]               = cfg_r.fsebyp;
        rdata_out[PCRB_LOCK_BIT]                 = lock_in;
    end

    // ratios: ref = r+1, feedback = 2*(f+1), output = 2**q
    assign ctl_out.ref_ratio  = {1'b0, cfg_r.ref_div} + PCRB_ONE7;
    assign ctl_out.fb_ratio   = ({2'b00, cfg_r.fb_div} + PCRB_ONE11) << 1;
    assign ctl_out.out_shift  = cfg_r.out_div;
    assign ctl_out.out_bad    = (cfg_r.out_div > PCRB_OUT_MAX);
    assign ctl_out.bypass     = cfg_r.byp;
    assign ctl_out.fse_bypass = cfg_r.fsebyp;
    assign ctl_out.range      = cfg_r.range;

endmodule

// *** rtl/pcrb_out_gate.sv ***
/*
 * one pll output gate word: a single clock enable bit at the top of the word.
 * assumes the bank decodes the address and hands in a one-cycle write pulse.
 */
`timescale 1ns/10ps
module pcrb_out_gate
    import pcrb_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        wr_in,
    input  wire logic [31:0] wdata_in,
    output logic      [31:0] rdata_out,
    output logic             cke_out
);

    logic cke_r;
    logic cke_nxt;

    // only the enable bit is stored; the rest of the word is dropped
    always_comb begin
        cke_nxt = wr_in ? wdata_in[PCRB_CKE_BIT] : cke_r;
    end

    // enable starts low so the pll output stays gated until software opens it
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cke_r <= PCRB_CKE_RST;
        end else begin
            cke_r <= cke_nxt;
        end
    end

    always_comb begin
        rdata_out               = PCRB_ZERO;
        rdata_out[PCRB_CKE_BIT] = cke_r;
    end

    assign cke_out = cke_r;

endmodule

// *** rtl/pcrb_pkg.sv ***
/*
 * package for the pll configuration register bank: offsets, field layout,
 * reset values and the carrier structs shared by the bank and its helpers.
 * assumes a plain strobe register port with 8-bit byte addresses.
 */
package pcrb_pkg;

    localparam int          PCRB_AW            = 8;
    localparam int          PCRB_DW            = 32;
    localparam int          PCRB_NUM_CFG       = 4;

    // register byte offsets
    localparam logic [7:0]  PCRB_OFF_MEM_CFG   = 8'h0C;
    localparam logic [7:0]  PCRB_OFF_MEM_GATE  = 8'h10;
    localparam logic [7:0]  PCRB_OFF_NET_CFG   = 8'h1C;
    localparam logic [7:0]  PCRB_OFF_NET_GATE  = 8'h20;
    localparam logic [7:0]  PCRB_OFF_ALT_CFG   = 8'h38;
    localparam logic [7:0]  PCRB_OFF_ALT_GATE  = 8'h3C;
    localparam logic [7:0]  PCRB_OFF_PER_CFG   = 8'h50;
    localparam logic [7:0]  PCRB_OFF_PER_GATE  = 8'h54;
    localparam logic [7:0]  PCRB_OFF_PER_DIV   = 8'h5C;

    // pll index for each instance
    localparam int          PCRB_IDX_MEM       = 0;
    localparam int          PCRB_IDX_NET       = 1;
    localparam int          PCRB_IDX_ALT       = 2;
    localparam int          PCRB_IDX_PER       = 3;

    // configuration word field positions
    localparam int          PCRB_REF_LSB       = 0;
    localparam int          PCRB_REF_MSB       = 5;
    localparam int          PCRB_FB_LSB        = 6;
    localparam int          PCRB_FB_MSB        = 14;
    localparam int          PCRB_OUT_LSB       = 15;
    localparam int          PCRB_OUT_MSB       = 17;
    localparam int          PCRB_RANGE_LSB     = 18;
    localparam int          PCRB_RANGE_MSB     = 20;
    localparam int          PCRB_BYP_BIT       = 24;
    localparam int          PCRB_FSEBYP_BIT    = 25;
    localparam int          PCRB_LOCK_BIT      = 31;
    localparam int          PCRB_CKE_BIT       = 31;

    // reset values
    localparam logic [5:0]  PCRB_REF_RST       = 6'h01;
    localparam logic [8:0]  PCRB_FB_RST        = 9'h01F;
    localparam logic [2:0]  PCRB_OUT_RST       = 3'h3;
    localparam logic [2:0]  PCRB_RANGE_RST     = 3'h0;
    localparam logic        PCRB_BYP_RST       = 1'b1;
    localparam logic        PCRB_FSEBYP_RST    = 1'b1;
    localparam logic        PCRB_CKE_RST       = 1'b0;
    localparam logic [31:0] PCRB_DIV_RST       = 32'h0000_0000;
    localparam logic [31:0] PCRB_ZERO          = 32'h0000_0000;

    // derived divider arithmetic
    localparam logic [2:0]  PCRB_OUT_MAX       = 3'h6;
    localparam logic [6:0]  PCRB_ONE7          = 7'h01;
    localparam logic [10:0] PCRB_ONE11         = 11'h001;

    typedef struct packed {
        logic [PCRB_AW-1:0] addr;
        logic [PCRB_DW-1:0] wdata;
        logic               wr;
        logic               rd;
    } pcrb_req_t;

    typedef struct packed {
        logic       fsebyp;
        logic       byp;
        logic [2:0] range;
        logic [2:0] out_div;
        logic [8:0] fb_div;
        logic [5:0] ref_div;
    } pcrb_cfg_t;

    typedef struct packed {
        logic [6:0]  ref_ratio;
        logic [10:0] fb_ratio;
        logic [2:0]  out_shift;
        logic        out_bad;
        logic        bypass;
        logic        fse_bypass;
        logic [2:0]  range;
    } pcrb_ctl_t;

endpackage

// *** sim/pcrb_bank_monitor.sv ***
/* checker for the pll register bank: read answers, divider arithmetic and gates.
   assumes it is bound to pcrb_bank and sees only its ports. */
`timescale 1ns/10ps
module pcrb_bank_monitor
    import pcrb_pkg::*;
#(
    parameter int NUM_PLL = 4
) (
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    input  wire logic [7:0]         addr_in,
    input  wire logic [31:0]        wdata_in,
    input  wire logic               wr_in,
    input  wire logic               rd_in,
    input  wire logic [31:0]        rdata_out,
    input  wire logic [NUM_PLL-1:0] lock_in,
    input  pcrb_ctl_t               ctl_out [NUM_PLL],
    input  wire logic [NUM_PLL-1:0] cke_out,
    input  wire logic [NUM_PLL-1:0] unsupported_out,
    input  wire logic [31:0]        periph_div_out
);
    // one clock domain, so clocking and reset are given once
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // write decodes shared by the properties
    wire w_mem = wr_in && addr_in == 8'h0C;
    wire w_gate = wr_in && addr_in == 8'h10;
    wire w_per = wr_in && addr_in == 8'h50;
    wire w_div = wr_in && addr_in == 8'h5C;

    chk_cke_reset: assert property ($past(!rst_n_in) |-> cke_out == {NUM_PLL{1'b0}})
        else $error("clock enable set after reset");
    chk_div_write: assert property (w_div |=> periph_div_out == $past(wdata_in))
        else $error("divider value not written");
    chk_div_hold: assert property (!w_div |=> $stable(periph_div_out))
        else $error("divider value changed without write");
    chk_cke_own: assert property (w_gate |=> cke_out[0] == $past(wdata_in[31]) && $stable(cke_out[3:1]))
        else $error("gate write reached wrong pll");
    chk_ref_ratio: assert property (w_mem |=> ctl_out[0].ref_ratio == {1'b0, $past(wdata_in[5:0])} + 7'h01)
        else $error("reference ratio wrong");
    chk_fb_ratio: assert property (w_mem |=> ctl_out[0].fb_ratio == {1'b0, $past(wdata_in[14:6]), 1'b0} + 11'h002)
        else $error("feedback ratio wrong");
    chk_out_bad: assert property (w_mem |=> unsupported_out[0] == ($past(wdata_in[17:15]) == 3'h7))
        else $error("unsupported flag wrong");
    chk_bypass_bits: assert property (w_per |=> ctl_out[3].bypass == $past(wdata_in[24]) &&
        ctl_out[3].fse_bypass == $past(wdata_in[25]))
        else $error("bypass bits not written");
    chk_lock_live: assert property (rd_in && addr_in == 8'h1C |=>
        rdata_out[31] == ($past(lock_in[1]) && !$past(ctl_out[1].bypass)))
        else $error("lock bit not live");
    chk_rsvd_zero: assert property (rd_in && addr_in == 8'h0C |=>
        rdata_out[30:26] == 5'h00 && rdata_out[23:21] == 3'h0)
        else $error("reserved bits not zero");
    chk_unmapped_zero: assert property (rd_in && addr_in == 8'h44 |=> rdata_out == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule

bind pcrb_bank pcrb_bank_monitor #(.NUM_PLL(NUM_PLL)) pcrb_bank_monitor_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .lock_in(lock_in), .ctl_out(ctl_out), .cke_out(cke_out), .unsupported_out(unsupported_out),
    .periph_div_out(periph_div_out));

// *** sim/pcrb_bank_tb_top.sv ***
/* self-checking bench for the pll register bank.
   assumes reads answer one cycle after the strobe and writes land at that edge. */
`timescale 1ns/10ps
module pcrb_bank_tb_top;
    import pcrb_pkg::*;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } pcrb_row_t;
    logic        clk_in   = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [7:0]  addr_in  = 8'h00;
    logic [31:0] wdata_in = 32'h0000_0000;
    logic        wr_in    = 1'b0;
    logic        rd_in    = 1'b0;
    logic [3:0]  lock_in  = 4'hF;
    logic [31:0] rdata_out, periph_div_out, got;
    logic [3:0]  cke_out, unsupported_out;
    pcrb_ctl_t   ctl_out [4];
    int          n_errors   = 0;
    int          n_compared = 0;
    int          cycles     = 0;
    // reserved and lock bits are written as ones to prove they are dropped
    pcrb_row_t   rows [10] = '{'{8'h0C, 32'hFFFF_FFFF, 32'h031F_FFFF}, '{8'h1C, 32'hFCE2_9300, 32'h8002_9300},
        '{8'h10, 32'hFFFF_FFFF, 32'h8000_0000}, '{8'h20, 32'h7FFF_FFFF, 32'h0000_0000},
        '{8'h38, 32'h0000_0000, 32'h8000_0000}, '{8'h3C, 32'h8000_0000, 32'h8000_0000},
        '{8'h50, 32'h011C_0000, 32'h011C_0000}, '{8'h54, 32'hFFFF_FFFF, 32'h8000_0000},
        '{8'h5C, 32'hA5A5_5A5A, 32'hA5A5_5A5A}, '{8'h44, 32'hFFFF_FFFF, 32'h0000_0000}};

    pcrb_bank pcrb_bank_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .lock_in(lock_in), .ctl_out(ctl_out),
        .cke_out(cke_out), .unsupported_out(unsupported_out), .periph_div_out(periph_div_out));

    // 125 MHz clock
    always #4 clk_in = ~clk_in;

    // hang guard: the whole run needs well under a hundred cycles a row
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            results();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 got = rdata_out;
    endtask

    task automatic results;
        $display("counts: %0d compared, %0d wrong", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // main sequence: reset values, table, then the awkward cases
    initial begin
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd_reg(8'h0C);
        check("mem cfg reset", 32'h0301_87C1, got);
        rd_reg(8'h54);
        check("per gate reset", 32'h0000_0000, got);
        rd_reg(8'h5C);
        check("div reset", 32'h0000_0000, got);
        check("cke reset", 32'h0000_0000, {28'h0, cke_out});
        $display("reset test done");
        foreach (rows[i]) begin
            wr_reg(rows[i].addr, rows[i].wdata);
            rd_reg(rows[i].addr);
            check("table readback", rows[i].exp, got);
        end
        $display("table test done");
        check("gates", 32'h0000_000D, {28'h0, cke_out});
        check("unsupported", 32'h0000_0001, {28'h0, unsupported_out});
        check("net ref", 32'h0000_0001, {25'h0, ctl_out[1].ref_ratio});
        check("net fb", 32'h0000_009A, {21'h0, ctl_out[1].fb_ratio});
        check("net shift", 32'h0000_0005, {29'h0, ctl_out[1].out_shift});
        check("per bypass", 32'h0000_0001, {31'h0, ctl_out[3].bypass});
        check("per range", 32'h0000_0007, {29'h0, ctl_out[3].range});
        check("div out", 32'hA5A5_5A5A, periph_div_out);
        // drop the network pll lock on a clock edge, then read it back live
        @(posedge clk_in);
        lock_in <= 4'hD;
        rd_reg(8'h1C);
        check("lock dropped", 32'h0002_9300, got);
        // read data must fall back to zero once its one cycle is over
        @(posedge clk_in);
        #1 check("read data cleared", 32'h0000_0000, rdata_out);
        $display("derived test done");
        // reset again in mid-run, with registers far from their reset values
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        #1 check("cke second reset", 32'h0000_0000, {28'h0, cke_out});
        check("div second reset", 32'h0000_0000, periph_div_out);
        rd_reg(8'h1C);
        check("net cfg second reset", 32'h0301_87C1, got);
        $display("second reset test done");
        results();
    end
endmodule
